// ===== rtl/vmt_pkg.sv
package vmt_pkg;

   // Bus geometry
   localparam int AXI_AW = 6;
   localparam int AXI_DW = 32;

   // Register byte addresses
   localparam logic [AXI_AW-1:0] ADDR_CMD      = 6'h00;
   localparam logic [AXI_AW-1:0] ADDR_CFG      = 6'h04;
   localparam logic [AXI_AW-1:0] ADDR_FIELD    = 6'h08;
   localparam logic [AXI_AW-1:0] ADDR_WDATA_LO = 6'h0c;
   localparam logic [AXI_AW-1:0] ADDR_WDATA_HI = 6'h10;
   localparam logic [AXI_AW-1:0] ADDR_RDATA_LO = 6'h14;
   localparam logic [AXI_AW-1:0] ADDR_RDATA_HI = 6'h18;
   localparam logic [AXI_AW-1:0] ADDR_STATUS   = 6'h1c;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Command opcodes, CMD bits [2:0]; CMD bit 4 marks the hypervisor call op
   localparam logic [2:0] OP_NONE     = 3'h0;
   localparam logic [2:0] OP_FIELD_RD = 3'h1;
   localparam logic [2:0] OP_FIELD_WR = 3'h2;
   localparam logic [2:0] OP_VM_ENTRY = 3'h3;
   localparam logic [2:0] OP_VM_EXIT  = 3'h4;
   localparam logic [2:0] OP_EXEC     = 3'h5;
   localparam logic [2:0] OP_HOST_LME = 3'h6;
   localparam int         CMD_OP_LSB  = 0;
   localparam int         CMD_HCALL   = 4;

   // Execution modes of the issuing software
   localparam logic [1:0] MODE_32     = 2'h0;
   localparam logic [1:0] MODE_COMPAT = 2'h1;
   localparam logic [1:0] MODE_64     = 2'h2;

   // Control structure field encodings
   localparam logic [31:0] ENC_BITMAP_FULL = 32'h00002004;
   localparam logic [31:0] ENC_BITMAP_HI   = 32'h00002005;
   localparam logic [31:0] ENC_NATURAL     = 32'h00006800;

   localparam logic [31:0] ZERO32 = 32'h00000000;

   // Configuration register image, bit 0 upward from exec_mode
   typedef struct packed {
      logic [17:0] rsvd;
      logic        host_lme;
      logic        exit_img_lme;
      logic        exit_img_vld;
      logic        ent_img_lme;
      logic        ent_img_vld;
      logic        host_pae;
      logic        host_pg;
      logic        guest_cs_l;
      logic        guest_pae;
      logic        guest_pg;
      logic        lmg_ctl;
      logic        host_asz;
      logic [1:0]  exec_mode;
   } vmt_cfg_t;

   // Status register image
   typedef struct packed {
      logic [21:0] rsvd;
      logic        bad_enc;
      logic        ud;
      logic        entry_fail;
      logic        abort;
      logic        busy;
      logic        sub64;
      logic        in_guest;
      logic        cs_l;
      logic        long_mode_active;
      logic        long_mode_enable;
   } vmt_status_t;

   localparam vmt_cfg_t CFG_RESET = '0;

endpackage

// ===== rtl/vmt_field_store.sv
`timescale 1ns/10ps
module vmt_field_store #(
   parameter logic [31:0] NATURAL_ENC = vmt_pkg::ENC_NATURAL
) (
   input  logic        mclk,
   input  logic        rst_n,
   input  logic        op_rd,
   input  logic        op_wr,
   input  logic [31:0] enc,
   input  logic        mode64,
   input  logic [63:0] wdata,
   output logic [63:0] rdata,
   output logic        rd_vld,
   output logic        bad_enc
);
   import vmt_pkg::*;

   logic [63:0] natural_r;
   logic [63:0] bitmap_r;
   logic [63:0] rdata_r;
   logic        rd_vld_r;
   logic        bad_enc_r;

   // Encoding decode; outside 64-bit mode only the low word moves
   wire         hit_nat  = (enc == NATURAL_ENC);
   wire         hit_full = (enc == ENC_BITMAP_FULL);
   wire         hit_hi   = (enc == ENC_BITMAP_HI);
   wire         hit_any  = hit_nat | hit_full | hit_hi;
   wire  [63:0] wr_sized = mode64 ? wdata : {ZERO32, wdata[31:0]};
   wire  [63:0] nat_rd   = mode64 ? natural_r : {ZERO32, natural_r[31:0]};
   wire  [63:0] full_rd  = mode64 ? bitmap_r : {ZERO32, bitmap_r[31:0]};
   wire  [63:0] hi_rd    = {ZERO32, bitmap_r[63:32]};
   wire  [63:0] rd_sel   = hit_nat ? nat_rd : (hit_full ? full_rd : (hit_hi ? hi_rd : '0));
   wire  [63:0] hi_wr    = {wdata[31:0], bitmap_r[31:0]};

   // Field storage; the upper-half encoding leaves the low word untouched
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         natural_r <= '0;
         bitmap_r  <= '0;
      end else if (op_wr) begin
         if (hit_nat) natural_r <= wr_sized;
         if (hit_full) bitmap_r <= wr_sized;
         if (hit_hi) bitmap_r <= hi_wr;
      end
   end

   // Read result and error flag, both one cycle after the request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r   <= '0;
         rd_vld_r  <= 1'b0;
         bad_enc_r <= 1'b0;
      end else begin
         rd_vld_r  <= op_rd;
         bad_enc_r <= (op_rd | op_wr) & ~hit_any;
         if (op_rd) rdata_r <= rd_sel;
      end
   end

   assign rdata   = rdata_r;
   assign rd_vld  = rd_vld_r;
   assign bad_enc = bad_enc_r;

endmodule

// ===== rtl/vmt_top.sv
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module vmt_top #(
   parameter logic [31:0] NATURAL_ENC = vmt_pkg::ENC_NATURAL
) (
   input  logic                        mclk,
   input  logic                        reset_n,
   input  logic [vmt_pkg::AXI_AW-1:0]  s_axi_awaddr,
   input  logic                        s_axi_awvalid,
   output logic                        s_axi_awready,
   input  logic [vmt_pkg::AXI_DW-1:0]  s_axi_wdata,
   input  logic [3:0]                  s_axi_wstrb,
   input  logic                        s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  logic                        s_axi_bready,
   input  logic [vmt_pkg::AXI_AW-1:0]  s_axi_araddr,
   input  logic                        s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [vmt_pkg::AXI_DW-1:0]  s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  logic                        s_axi_rready
);
   import vmt_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ENT_LME, ST_ENT_IMG, ST_EXIT_LM, ST_EXIT_IMG, ST_ABORT
   } vmt_state_t;

   // Reset release through two flops
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Bus slave state
   logic [AXI_AW-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              aw_got_r;
   logic              w_got_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              arready_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;

   // Software visible registers and block state
   vmt_cfg_t          cfg_r;
   logic [31:0]       cmd_r;
   logic [31:0]       enc_r;
   logic [31:0]       wlo_r;
   logic [31:0]       whi_r;
   vmt_state_t        state_r;
   vmt_state_t        state_nxt;
   logic              lme_r;
   logic              lma_r;
   logic              cs_l_r;
   logic              in_guest_r;
   logic              sub64_r;
   logic              abort_r;
   logic              entry_fail_r;
   logic              ud_r;
   logic              bad_enc_r;
   logic              fs_mode64_r;
   logic [63:0]       fs_rdata;
   logic              fs_rd_vld;
   logic              fs_bad_enc;

   // Write channel joins: address and data may arrive in either order
   wire              aw_hs    = s_axi_awvalid & awready_r;
   wire              w_hs     = s_axi_wvalid & wready_r;
   wire              aw_have  = aw_got_r | aw_hs;
   wire              w_have   = w_got_r | w_hs;
   wire              do_wr    = aw_have & w_have;
   wire [AXI_AW-1:0] wr_addr  = aw_got_r ? awaddr_r : s_axi_awaddr;
   wire [31:0]       wr_data  = w_got_r ? wdata_r : s_axi_wdata;
   wire [3:0]        wr_strb  = w_got_r ? wstrb_r : s_axi_wstrb;
   wire [31:0]       wr_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}},
                                 {8{wr_strb[0]}}};
   wire              bvalid_nxt  = do_wr | (bvalid_r & ~s_axi_bready);
   wire              aw_got_nxt  = aw_have & ~do_wr;
   wire              w_got_nxt   = w_have & ~do_wr;
   wire              ar_hs       = s_axi_arvalid & arready_r;
   wire              rvalid_nxt  = ar_hs | (rvalid_r & ~s_axi_rready);

   // Write decode
   wire sel_cmd   = (wr_addr == ADDR_CMD);
   wire sel_cfg   = (wr_addr == ADDR_CFG);
   wire sel_field = (wr_addr == ADDR_FIELD);
   wire sel_wlo   = (wr_addr == ADDR_WDATA_LO);
   wire sel_whi   = (wr_addr == ADDR_WDATA_HI);
   wire wr_ro     = (wr_addr == ADDR_RDATA_LO) | (wr_addr == ADDR_RDATA_HI)
                  | (wr_addr == ADDR_STATUS);
   wire wr_known  = sel_cmd | sel_cfg | sel_field | sel_wlo | sel_whi | wr_ro;
   wire [31:0] merged_cmd = (cmd_r & ~wr_mask) | (wr_data & wr_mask);

   // Command acceptance: only when idle, otherwise the write is dropped
   wire        cmd_go   = do_wr & sel_cmd & (state_r == ST_IDLE);
   wire [2:0]  cmd_op   = merged_cmd[CMD_OP_LSB +: 3];
   wire        cmd_hc   = merged_cmd[CMD_HCALL];
   wire        compat   = (cfg_r.exec_mode == MODE_COMPAT);
   wire        is_op    = (cmd_op != OP_NONE);
   wire        illegal  = compat & is_op & ~((cmd_op == OP_EXEC) & cmd_hc);
   wire        go_ok    = cmd_go & ~illegal;
   wire        go_entry = go_ok & (cmd_op == OP_VM_ENTRY) & ~in_guest_r;
   wire        go_exit  = go_ok & (cmd_op == OP_VM_EXIT) & in_guest_r;
   wire        fs_rd    = go_ok & (cmd_op == OP_FIELD_RD);
   wire        fs_wr    = go_ok & (cmd_op == OP_FIELD_WR);
   wire        set_hlme = go_ok & (cmd_op == OP_HOST_LME) & ~in_guest_r;

   // Long-mode guest needs guest paging, extension and a long-mode host
   wire lm_host  = lma_r & cfg_r.host_asz;
   wire ent_ok   = ~cfg_r.lmg_ctl | (cfg_r.guest_pg & cfg_r.guest_pae & lm_host);
   wire ent_img_bad  = cfg_r.ent_img_vld & (cfg_r.ent_img_lme != cfg_r.lmg_ctl);
   wire exit_img_bad = cfg_r.exit_img_vld & (cfg_r.exit_img_lme != cfg_r.host_asz);

   // Paging controls in force depend on which side currently runs
   wire cur_pg   = in_guest_r ? cfg_r.guest_pg : cfg_r.host_pg;
   wire cur_pae  = in_guest_r ? cfg_r.guest_pae : cfg_r.host_pae;

   // Sequencer: enable bits always land before any load image is judged
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (go_entry) state_nxt = ent_ok ? ST_ENT_LME : ST_EXIT_LM;
            else if (go_exit) state_nxt = ST_EXIT_LM;
         end
         ST_ENT_LME:  state_nxt = ST_ENT_IMG;
         ST_ENT_IMG:  state_nxt = ent_img_bad ? ST_EXIT_LM : ST_IDLE;
         ST_EXIT_LM:  state_nxt = ST_EXIT_IMG;
         ST_EXIT_IMG: state_nxt = exit_img_bad ? ST_ABORT : ST_IDLE;
         ST_ABORT:    state_nxt = ST_ABORT;
         default:     state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) state_r <= ST_IDLE;
      else state_r <= state_nxt;
   end

   // Mode bits; the active bit is always derived, except the exit copy
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         lme_r      <= 1'b0;
         lma_r      <= 1'b0;
         cs_l_r     <= 1'b0;
         in_guest_r <= 1'b0;
         sub64_r    <= 1'b0;
      end else begin
         if (state_r == ST_EXIT_LM) lma_r <= cfg_r.host_asz;
         else lma_r <= lme_r & cur_pg & cur_pae;
         if (state_r == ST_EXIT_LM) begin
            lme_r      <= cfg_r.host_asz;
            cs_l_r     <= cfg_r.host_asz;
            in_guest_r <= 1'b0;
            sub64_r    <= 1'b0;
         end else if (state_r == ST_ENT_LME) begin
            lme_r <= cfg_r.lmg_ctl;
         end else if (state_r == ST_ENT_IMG && !ent_img_bad) begin
            in_guest_r <= 1'b1;
            cs_l_r     <= cfg_r.guest_cs_l;
            sub64_r    <= cfg_r.lmg_ctl & cfg_r.guest_cs_l;
         end else if (set_hlme) begin
            lme_r <= cfg_r.host_lme;
         end
      end
   end

   // Outcome flags: cleared by the next accepted command, abort holds
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         abort_r      <= 1'b0;
         entry_fail_r <= 1'b0;
         ud_r         <= 1'b0;
         bad_enc_r    <= 1'b0;
      end else begin
         if (cmd_go) ud_r <= illegal;
         // The field store only pulses its error, so hold it here for software
         if (fs_bad_enc) bad_enc_r <= 1'b1;                               // Set wins
         else if (cmd_go) bad_enc_r <= 1'b0;
         if (state_r == ST_EXIT_IMG && exit_img_bad) abort_r <= 1'b1;
         if (go_entry) entry_fail_r <= ~ent_ok;
         else if (state_r == ST_ENT_IMG && ent_img_bad) entry_fail_r <= 1'b1;
         else if (cmd_go) entry_fail_r <= 1'b0;
      end
   end

   // Field width follows the mode of the issuing software
   wire fs_mode64 = (cfg_r.exec_mode == MODE_64);

   vmt_field_store #(
      .NATURAL_ENC (NATURAL_ENC)
   ) u_field (
      .mclk    (mclk),
      .rst_n   (rst_n_r),
      .op_rd   (fs_rd),
      .op_wr   (fs_wr),
      .enc     (enc_r),
      .mode64  (fs_mode64),
      .wdata   ({whi_r, wlo_r}),
      .rdata   (fs_rdata),
      .rd_vld  (fs_rd_vld),
      .bad_enc (fs_bad_enc)
   );

   // Mode sampled with the read, for the width check below
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) fs_mode64_r <= 1'b0;
      else if (fs_rd) fs_mode64_r <= fs_mode64;
   end

   // Register writes with byte strobes
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cfg_r <= CFG_RESET;
         cmd_r <= '0;
         enc_r <= '0;
         wlo_r <= '0;
         whi_r <= '0;
      end else if (do_wr) begin
         if (sel_cfg) cfg_r <= (cfg_r & ~wr_mask) | (wr_data & wr_mask);
         if (cmd_go) cmd_r <= merged_cmd;
         if (sel_field) enc_r <= (enc_r & ~wr_mask) | (wr_data & wr_mask);
         if (sel_wlo) wlo_r <= (wlo_r & ~wr_mask) | (wr_data & wr_mask);
         if (sel_whi) whi_r <= (whi_r & ~wr_mask) | (wr_data & wr_mask);
      end
   end

   // Status image and read mux
   vmt_status_t status;
   always_comb begin
      status            = '0;
      status.long_mode_enable        = lme_r;
      status.long_mode_active        = lma_r;
      status.cs_l       = cs_l_r;
      status.in_guest   = in_guest_r;
      status.sub64      = sub64_r;
      status.busy       = (state_r != ST_IDLE);
      status.abort      = abort_r;
      status.entry_fail = entry_fail_r;
      status.ud         = ud_r;
      status.bad_enc    = bad_enc_r;
   end

   wire        rd_known = (s_axi_araddr <= ADDR_STATUS) & (s_axi_araddr[1:0] == 2'h0);
   logic [31:0] rd_mux;
   always_comb begin
      case (s_axi_araddr)
         ADDR_CMD:      rd_mux = cmd_r;
         ADDR_CFG:      rd_mux = cfg_r;
         ADDR_FIELD:    rd_mux = enc_r;
         ADDR_WDATA_LO: rd_mux = wlo_r;
         ADDR_WDATA_HI: rd_mux = whi_r;
         ADDR_RDATA_LO: rd_mux = fs_rdata[31:0];
         ADDR_RDATA_HI: rd_mux = fs_rdata[63:32];
         ADDR_STATUS:   rd_mux = status;
         default:       rd_mux = '0;
      endcase
   end

   // Bus handshake flops; ready drops while a response waits
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= RESP_OKAY;
      end else begin
         aw_got_r  <= aw_got_nxt;
         w_got_r   <= w_got_nxt;
         awready_r <= ~aw_got_nxt & ~bvalid_nxt;
         wready_r  <= ~w_got_nxt & ~bvalid_nxt;
         bvalid_r  <= bvalid_nxt;
         arready_r <= ~rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (aw_hs) awaddr_r <= s_axi_awaddr;
         if (w_hs) wdata_r <= s_axi_wdata;
         if (w_hs) wstrb_r <= s_axi_wstrb;
         if (do_wr) bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
         if (ar_hs) rdata_r <= rd_mux;
         if (ar_hs) rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // Checks on the sequencer and field widths
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n_r);

   a_exit_copy_asz: assert property (state_r == ST_EXIT_LM |=>
      lme_r == $past(cfg_r.host_asz) && lma_r == $past(cfg_r.host_asz)
      && cs_l_r == $past(cfg_r.host_asz) && !in_guest_r)
      else $error("exit did not copy host size control");
   a_exit_order: assert property (state_r == ST_EXIT_IMG |->
      $past(state_r) == ST_EXIT_LM)
      else $error("exit image judged before mode bits");
   a_exit_abort: assert property (state_r == ST_EXIT_IMG && exit_img_bad |=>
      state_r == ST_ABORT && abort_r)
      else $error("exit image mismatch did not abort");
   a_lma_derive: assert property ($past(state_r) != ST_EXIT_LM |->
      lma_r == $past(lme_r & cur_pg & cur_pae))
      else $error("active bit not derived");
   a_entry_cond: assert property (go_entry && cfg_r.lmg_ctl && !lm_host |=>
      state_r == ST_EXIT_LM && entry_fail_r ##1 state_r == ST_EXIT_IMG)
      else $error("long mode guest entry from non long host");
   a_entry_fail: assert property (go_entry && !ent_ok |=> ##1 !in_guest_r
      && lme_r == $past(cfg_r.host_asz, 2))
      else $error("failed entry did not load host state");
   a_entry_order: assert property (state_r == ST_ENT_IMG |->
      lme_r == cfg_r.lmg_ctl && $past(state_r) == ST_ENT_LME)
      else $error("entry enable not loaded first");
   a_entry_img: assert property (state_r == ST_ENT_IMG && ent_img_bad |=>
      entry_fail_r && state_r == ST_EXIT_LM)
      else $error("entry image mismatch accepted");
   a_compat_ud: assert property (cmd_go && illegal |=> ud_r && state_r == ST_IDLE)
      else $error("compat op not refused");
   a_field_width: assert property (fs_rd_vld && !fs_mode64_r |->
      fs_rdata[63:32] == ZERO32)
      else $error("upper word leaked outside 64-bit mode");
   a_sub_mode: assert property (state_r == ST_ENT_IMG && !ent_img_bad |=>
      in_guest_r && sub64_r == $past(cfg_r.lmg_ctl & cfg_r.guest_cs_l))
      else $error("wrong guest sub-mode");

   c_entry_ok:   cover property (state_r == ST_ENT_IMG && !ent_img_bad);
   c_entry_fail: cover property (go_entry && !ent_ok);
   c_abort:      cover property (state_r == ST_ABORT);
   c_exit:       cover property (go_exit ##3 state_r == ST_IDLE);

endmodule

// ===== tb/vmt_axi_master.sv
`timescale 1ns/10ps
// Register bus master in place of hypervisor software, one write or read at a time
module vmt_axi_master (
   input  logic        mclk,
   output logic [5:0]  awaddr,
   output logic        awvalid,
   input  logic        awready,
   output logic [31:0] wdata,
   output logic [3:0]  wstrb,
   output logic        wvalid,
   input  logic        wready,
   input  logic        bvalid,
   output logic        bready,
   output logic [5:0]  araddr,
   output logic        arvalid,
   input  logic        arready,
   input  logic [31:0] rdata,
   input  logic        rvalid,
   output logic        rready
);
   // Whole words only, so every strobe stays on
   assign wstrb = 4'hf;
   initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;

   // Each channel holds its payload until the edge that takes it
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge mclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      do begin
         @(posedge mclk);
         {awvalid, wvalid} <= {awvalid & ~awready, wvalid & ~wready};
      end while (!bvalid);
      bready <= 1'b0;
   endtask

   // Read data is taken at the same edge that shows rvalid
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge mclk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do begin
         @(posedge mclk);
         arvalid <= arvalid & ~arready;
      end while (!rvalid);
      d = rdata;
      rready <= 1'b0;
   endtask
endmodule

// ===== tb/vmt_top_tb_top.sv
`timescale 1ns/10ps
module vmt_top_tb_top;
   import vmt_pkg::*;
   logic        mclk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, got, en;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, md;
   logic [63:0] d, d2;
   logic [65:0] note, notes[$];
   logic [1:0]  bexp, bnotes[$];
   int          bad_count, total_checks, cyc;
   // Long-mode host: size control set, paging on, enable loaded before any entry
   localparam logic [31:0] LH = 32'h21be;

   vmt_top DUT (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   vmt_axi_master host (.mclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Oldest note meets each read answer; the watchdog bounds a hung handshake
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rvalid && rready && notes.size() > 0) begin
         note = notes.pop_front();
         chk({rresp, rdata & note[65:34]}, note[33:0]);
      end
      // Write answers are OKAY unless a note asks for an error
      if (bvalid && bready) begin
         bexp = (bnotes.size() > 0) ? bnotes.pop_front() : RESP_OKAY;
         chk({32'h0, bresp}, {32'h0, bexp});
      end
      if (cyc == 30000) begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [33:0] seen, input logic [33:0] want);
      total_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] x, input logic [31:0] mk,
                         input logic [1:0] rs = RESP_OKAY);
      notes.push_back({mk, rs, x & mk});
      host.rd(a, got);
   endtask

   // Busy is polled under a bound, then the status image is checked
   task automatic cmd(input logic [31:0] cfg, input logic [2:0] op, input logic [31:0] x,
                      input logic [31:0] mk);
      host.wr(ADDR_CFG, cfg);
      host.wr(ADDR_CMD, {27'h0, op == OP_EXEC, 1'b0, op});
      got[5] = 1'b1;
      for (int i = 0; i < 8 && got[5] !== 1'b0; i++)
         rd_chk(ADDR_STATUS, 32'h0, 32'h0);
      rd_chk(ADDR_STATUS, x, mk);
      $display("test op %0d done", op);
   endtask

   // Optional field write, then a read back in the given mode
   task automatic fld(input logic w_on, input logic [1:0] m, input logic [31:0] e,
                      input logic [63:0] w, input logic [63:0] x);
      host.wr(ADDR_CFG, {30'h0, m});
      host.wr(ADDR_FIELD, e);
      if (w_on) begin
         host.wr(ADDR_WDATA_LO, w[31:0]);
         host.wr(ADDR_WDATA_HI, w[63:32]);
         host.wr(ADDR_CMD, {29'h0, OP_FIELD_WR});
      end
      host.wr(ADDR_CMD, {29'h0, OP_FIELD_RD});
      rd_chk(ADDR_RDATA_LO, x[31:0], 32'hffffffff);
      rd_chk(ADDR_RDATA_HI, x[63:32], 32'hffffffff);
      $display("test field %h done", e);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      reset_n = 1'b0;
      void'($urandom(32'h03ae));
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      rd_chk(ADDR_STATUS, 32'h0, 32'h3ff);
      rd_chk(6'h20, 32'h0, 32'h0, RESP_SLVERR);
      bnotes.push_back(RESP_SLVERR);
      host.wr(6'h20, 32'h0);
      // Natural and bitmap fields are rewritten here, before any guest runs
      for (int i = 0; i < 4; i++) begin
         d = {$urandom, $urandom};
         md = i[0] ? MODE_64 : MODE_32;
         en = i[1] ? ENC_BITMAP_FULL : ENC_NATURAL;
         fld(1'b1, md, en, d, i[0] ? d : {32'h0, d[31:0]});
      end
      d2 = {$urandom, $urandom};
      fld(1'b1, MODE_32, ENC_BITMAP_HI, d2, {32'h0, d2[31:0]});
      fld(1'b0, MODE_64, ENC_BITMAP_FULL, d2, {d2[31:0], d[31:0]});
      host.wr(ADDR_FIELD, 32'h0);
      cmd(32'h2, OP_FIELD_RD, 32'h200, 32'h3ff);
      cmd(32'h1, OP_VM_ENTRY, 32'h100, 32'h3df);
      cmd(32'h1, OP_EXEC, 32'h0, 32'h3df);
      cmd(LH, OP_HOST_LME, 32'h3, 32'h3db);
      for (int i = 0; i < 2; i++) begin
         cmd({LH[31:7], i[0], LH[5:0]}, OP_VM_ENTRY, i ? 32'h1f : 32'h0b, 32'h3df);
         cmd(LH, OP_VM_EXIT, 32'h7, 32'h3cf);
      end
      cmd(LH & ~32'h10, OP_VM_ENTRY, 32'h87, 32'h3cf);
      cmd(LH | 32'h200, OP_VM_ENTRY, 32'h87, 32'h3cf);
      cmd(LH & ~32'h8, OP_VM_ENTRY, 32'h08, 32'h3db);
      cmd(LH, OP_VM_EXIT, 32'h7, 32'h3cf);
      cmd(LH & ~32'h2004, OP_HOST_LME, 32'h0, 32'h3db);
      cmd(LH & ~32'h2004, OP_VM_ENTRY, 32'h80, 32'h3cf);
      cmd(LH, OP_HOST_LME, 32'h3, 32'h3db);
      cmd(LH, OP_VM_ENTRY, 32'h0b, 32'h3df);
      cmd(LH | 32'h800, OP_VM_EXIT, 32'h44, 32'h3cc);
      wrap_up();
   end
endmodule
